// ---- design/fhs_handshake.v ----
// Fast-to-slow control crossing with acknowledge and retransmit
`timescale 1ns/10ps
`default_nettype none
`include "fhs_consts.vh"
// Sender side, fast domain
//   Idle: a request is taken while send_ready is high.
//   Send: the crossing signal is high; stretch mode counts
//   cycles, hold mode waits for the returned acknowledge.
//   Wait: signal low again; the timeout counter keeps
//   running from the cycle the signal rose.
//   Drop: acknowledge seen; completion waits for it to
//   fall so that the next request makes a fresh edge.
//
// Receiver side, slow domain
//   The synchronizer output is the only slow-domain copy;
//   the rise pulse is taken from it, one slow cycle late.
//
// Acknowledge path
//   The synchronized copy goes back through its own chain
//   in the fast domain. Latency from request to done is
//   roughly two synchronizer delays in each direction.
//
// Outputs
//   send_ready is decoded from the state register; all
//   other outputs come straight from flip-flops.
//   send_done and send_retry last one fast cycle each.
//   slow_side_rise lasts one slow cycle.
//
// Reset
//   Both domains reset together and release on their own
//   clocks through two flops each.
//
// Limitations
//   Stretch must exceed one slow period plus margin, and
//   the timeout must exceed the full round trip, or a
//   retransmit lands on a transfer that was caught.
//   Hold mode never retransmits: a stopped slow clock
//   leaves the sender busy until reset.
//   Stage counts below two are not supported.
//   The counter may wrap in a very long hold; harmless,
//   since hold mode never looks at it.

module fhs_handshake #(
    parameter SYNC_STAGES = `FHS_SYNC_STAGES,
    parameter ACK_STAGES = `FHS_ACK_STAGES,
    parameter [`FHS_CNT_W-1:0] STRETCH_CYCLES = `FHS_STRETCH_CYCLES,
    parameter [`FHS_CNT_W-1:0] TIMEOUT_CYCLES = `FHS_TIMEOUT_CYCLES
) (
    input wire sending_domain_clock,
    input wire receiving_domain_clock,
    input wire arst_n,
    input wire send_req,
    input wire hold_until_ack,
    output wire send_ready,
    output reg send_done,
    output reg send_retry,
    output reg fast_side_crossing_signal,
    output wire slow_side_synced_signal,
    output reg slow_side_rise
);
    reg [1:0] frst_q;
    reg [1:0] srst_q;
    wire frst_n;
    wire srst_n;
    wire ack_fast;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [`FHS_CNT_W-1:0] cnt_q;
    reg [`FHS_CNT_W-1:0] cnt_d;
    reg hold_q;
    reg hold_d;
    reg sig_d;
    reg done_d;
    reg retry_d;
    reg synced_last_q;

    // Decoded sender conditions
    wire take_req;
    wire stretch_over;
    wire timeout_hit;

    // Reset released through two flops in each domain.
    // Domains leave reset on their own clocks, not together,
    // so the sender waits for its own copy before a request.
    always @(posedge sending_domain_clock or negedge arst_n) begin
        if (!arst_n) begin
            frst_q <= 2'h0;
        end else begin
            frst_q <= {frst_q[0], 1'b1};
        end
    end
    assign frst_n = frst_q[1];

    always @(posedge receiving_domain_clock or negedge arst_n) begin
        if (!arst_n) begin
            srst_q <= 2'h0;
        end else begin
            srst_q <= {srst_q[0], 1'b1};
        end
    end
    assign srst_n = srst_q[1];

    // Forward path into the slow domain.
    // More stages raise the failure interval at the cost
    // of slow-domain latency.
    fhs_sync #(.STAGES(SYNC_STAGES)) u_fwd_sync (
        .clk(receiving_domain_clock),
        .rst_n(srst_n),
        .d(fast_side_crossing_signal),
        .q(slow_side_synced_signal)
    );

    // Edge taken from the last stage only, never from stage 0
    always @(posedge receiving_domain_clock or negedge srst_n) begin
        if (!srst_n) begin
            synced_last_q <= 1'b0;
            slow_side_rise <= 1'b0;
        end else begin
            synced_last_q <= slow_side_synced_signal;
            slow_side_rise <= slow_side_synced_signal & ~synced_last_q;
        end
    end

    // Acknowledge path back into the fast domain
    // Round trip sets the minimum usable timeout
    fhs_sync #(.STAGES(ACK_STAGES)) u_ack_sync (
        .clk(sending_domain_clock),
        .rst_n(frst_n),
        .d(slow_side_synced_signal),
        .q(ack_fast)
    );

    assign send_ready = (state_q == `FHS_ST_IDLE);

    assign take_req = send_ready & send_req;
    assign stretch_over = (cnt_q >= STRETCH_CYCLES - 1'b1);
    assign timeout_hit = (cnt_q >= TIMEOUT_CYCLES - 1'b1);

    // Next-state logic. Every output has a default first,
    // so no path leaves a latch; the counter runs unless
    // a state says otherwise.
    always @* begin
        state_d = state_q;
        cnt_d = cnt_q + 1'b1;
        hold_d = hold_q;
        sig_d = fast_side_crossing_signal;
        done_d = 1'b0;
        retry_d = 1'b0;

        case (state_q)
            `FHS_ST_IDLE: begin
                cnt_d = cnt_q;
                if (take_req) begin
                    state_d = `FHS_ST_SEND;
                    hold_d = hold_until_ack;
                    sig_d = 1'b1;
                    cnt_d = {`FHS_CNT_W{1'b0}};
                end
            end

            `FHS_ST_SEND: begin
                if (hold_q) begin
                    // Held until acknowledge, whatever the slow period
                    if (ack_fast) begin
                        sig_d = 1'b0;
                        state_d = `FHS_ST_DROP;
                    end
                end else if (stretch_over) begin
                    sig_d = 1'b0;
                    state_d = `FHS_ST_WAIT;
                end
            end

            `FHS_ST_WAIT: begin
                if (ack_fast) begin
                    state_d = `FHS_ST_DROP;
                end else if (timeout_hit) begin
                    state_d = `FHS_ST_SEND;
                    sig_d = 1'b1;
                    retry_d = 1'b1;
                    cnt_d = {`FHS_CNT_W{1'b0}};
                end
            end

            default: begin
                // Wait for ack to fall so the next send makes a fresh edge
                cnt_d = cnt_q;
                if (!ack_fast) begin
                    state_d = `FHS_ST_IDLE;
                    done_d = 1'b1;
                end
            end
        endcase
    end

    always @(posedge sending_domain_clock or negedge frst_n) begin
        if (!frst_n) begin
            state_q <= `FHS_ST_IDLE;
            cnt_q <= {`FHS_CNT_W{1'b0}};
            hold_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            hold_q <= hold_d;
        end
    end

    // Crossing signal leaves a flop, so the slow side never sees a decode glitch
    always @(posedge sending_domain_clock or negedge frst_n) begin
        if (!frst_n) begin
            fast_side_crossing_signal <= 1'b0;
        end else begin
            fast_side_crossing_signal <= sig_d;
        end
    end

    // Status pulses, one fast cycle each
    always @(posedge sending_domain_clock or negedge frst_n) begin
        if (!frst_n) begin
            send_done <= 1'b0;
            send_retry <= 1'b0;
        end else begin
            send_done <= done_d;
            send_retry <= retry_d;
        end
    end
endmodule // fhs_handshake
`default_nettype wire

// ---- design/fhs_consts.vh ----
// Constants for the fast-to-slow handshake synchronizer
`ifndef FHS_CONSTS_VH
`define FHS_CONSTS_VH
`define FHS_SYNC_STAGES 2
`define FHS_ACK_STAGES 2
`define FHS_STRETCH_CYCLES 8
`define FHS_TIMEOUT_CYCLES 32
`define FHS_CNT_W 16
`define FHS_ST_IDLE 2'h0
`define FHS_ST_SEND 2'h1
`define FHS_ST_WAIT 2'h2
`define FHS_ST_DROP 2'h3
`endif

// ---- design/fhs_sync.v ----
// Multi-stage flip-flop synchronizer for one level signal
`timescale 1ns/10ps
`default_nettype none
module fhs_sync #(
    parameter STAGES = 2
) (
    input wire clk,
    input wire rst_n,
    input wire d,
    output wire q
);
    reg [STAGES-1:0] chain_q;

    // Stage 0 feeds only stage 1; only the last stage leaves
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chain_q <= {STAGES{1'b0}};
        end else begin
            chain_q <= {chain_q[STAGES-2:0], d};
        end
    end

    assign q = chain_q[STAGES-1];
endmodule // fhs_sync
`default_nettype wire

// ---- sim/fhs_far.sv ----
// Slow far side model
`timescale 1ns/10ps
`default_nettype none
module fhs_far (
    input wire logic stall,
    input wire logic slow_side_rise,
    output logic receiving_domain_clock = 1'b0,
    output int rises = 0
);
    // Offset keeps slow edges off fast edges
    initial #0.01 forever #5.3 if (!stall) receiving_domain_clock = !receiving_domain_clock;
    always @(posedge receiving_domain_clock) if (slow_side_rise) rises++;
endmodule // fhs_far
`default_nettype wire

// ---- sim/fhs_chk_sva.sv ----
// Crossing checker
`timescale 1ns/10ps
`default_nettype none
module fhs_chk (
    input wire logic sending_domain_clock,
    input wire logic receiving_domain_clock,
    input wire logic arst_n,
    input wire logic send_ready,
    input wire logic send_done,
    input wire logic send_retry,
    input wire logic fast_side_crossing_signal,
    input wire logic slow_side_synced_signal
);
    wire f = sending_domain_clock;
    wire r = !arst_n;
    wire c = fast_side_crossing_signal;
    wire s = slow_side_synced_signal;
    property p_tk; @(posedge f) disable iff (r) $fell(send_ready) |-> c; endproperty
    a_tk: assert property (p_tk) else $error("tk");
    property p_hd; @(posedge f) disable iff (r) $rose(c) |-> c [*4]; endproperty
    a_hd: assert property (p_hd) else $error("hd");
    property p_sy; @(posedge receiving_domain_clock) disable iff (r) s == $past(c, 2); endproperty
    a_sy: assert property (p_sy) else $error("sy");
    property p_dn; @(posedge f) disable iff (r) send_done |-> !c && !s; endproperty
    a_dn: assert property (p_dn) else $error("dn");
    property p_rt; @(posedge f) disable iff (r) send_retry |=> c && !send_retry; endproperty
    a_rt: assert property (p_rt) else $error("rt");
    property p_bd; @(posedge f) disable iff (r) $rose(c) |-> ##[1:60] send_done || send_retry; endproperty
    a_bd: assert property (p_bd) else $error("bd");
endmodule // fhs_chk
`default_nettype wire

// ---- sim/fhs_handshake_tb.sv ----
// Crossing testbench
`timescale 1ns/10ps
`default_nettype none
module fhs_handshake_tb;
    logic sending_domain_clock = 0, arst_n = 0, send_req = 0, hold_until_ack = 0, stall = 0;
    wire receiving_domain_clock, send_ready, send_done, send_retry, slow_side_rise;
    wire fast_side_crossing_signal, slow_side_synced_signal;
    int rises, n0, r0, retries = 0, fails = 0, samples_checked = 0, cyc = 0;
    fhs_handshake #(.STRETCH_CYCLES(16'h4), .TIMEOUT_CYCLES(16'h10)) u_fhs_handshake (.*);
    fhs_far u_fhs_far (.*);
    always #2.5 sending_domain_clock = !sending_domain_clock;
    always @(posedge sending_domain_clock) if (send_retry) retries++;
    always @(posedge sending_domain_clock) begin
        if (++cyc == 2000) begin
            fails++;
            complete_run();
        end
    end
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("wrong value %s exp %0d got %0d", nm, exp, got);
            fails++;
        end
    endtask
    task chk_lvl(input string nm, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            $display("wrong value %s exp %b got %b", nm, exp, got);
            fails++;
        end
    endtask
    // Request held while busy must not start a second transfer
    task xfer(input logic h, input logic s);
        n0 = rises;
        r0 = retries;
        {hold_until_ack, stall, send_req} = {h, s, 1'b1};
        @(posedge sending_domain_clock);
        #1 chk_lvl("send_ready", 1'b0, send_ready);
        repeat (2) @(posedge sending_domain_clock);
        #1 send_req = 0;
        if (s) wait (send_retry) #1 stall = 0;
        wait (send_done) #1 chk("rises", 8'h1, 8'(rises - n0));
        chk_lvl("send_ready", 1'b1, send_ready);
        chk("retries", 8'(s), 8'(retries - r0));
    endtask
    task run_stretch;
        xfer(1'b0, 1'b0);
    endtask
    task run_hold;
        xfer(1'b1, 1'b0);
    endtask
    task run_retry;
        xfer(1'b0, 1'b1);
    endtask
    task complete_run;
        $display("%0d checks %0d fails", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #98.5 arst_n = 1;
        #15 run_stretch();
        run_hold();
        run_retry();
        run_stretch();
        complete_run();
    end
endmodule // fhs_handshake_tb
bind fhs_handshake fhs_chk u_fhs_chk (.*);
`default_nettype wire
